// *** logic/dbg_cmp_params.svh ***
// Purpose: offsets, reset values and field positions for the debug compare/trace block
// Assumes: APB byte addresses are four times the register index
// Notes: definitions only
`ifndef DBG_CMP_PARAMS_SVH
`define DBG_CMP_PARAMS_SVH

`define IDX_CMP_A_ADDR_LOW 4'h1
`define IDX_CMP_B_ADDR_HIGH 4'h2
`define IDX_CMP_B_ADDR_DATA_LOW 4'h3
`define IDX_CMP_C_ADDR_HIGH 4'h4
`define IDX_CMP_C_ADDR_LOW 4'h5
`define IDX_TRACE_WORD_HIGH 4'h6
`define IDX_TRACE_WORD_LOW 4'h7
`define IDX_CTRL 4'h8
`define IDX_STATUS 4'h9
`define IDX_LSB 2
`define IDX_MSB 5
`define RST_CMP_A_ADDR_LOW 8'h00
`define RST_CMP_B_ADDR_HIGH 8'h00
`define RST_CMP_B_ADDR_DATA_LOW 8'h00
`define RST_CMP_C_ADDR_HIGH 8'h00
`define RST_CMP_C_ADDR_LOW 8'h00
`define CTRL_FULL_BIT 0
`define CTRL_EVONLY_BIT 1
`define CTRL_ENABLE_BIT 7
`define CTRL_BEGIN_BIT 6
`define FIFO_DEPTH 8
`define FIFO_PTR_W 3
`define BYTE_ZERO 8'h00

`endif

// *** logic/dbg_cmp_pkg.sv ***
// Purpose: shared types of the debug compare/trace block
// Assumes: nothing
// Notes: constants live in dbg_cmp_params.svh
package dbg_cmp_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] word_t;
endpackage : dbg_cmp_pkg

// *** logic/cmp_bus_if.sv ***
// Purpose: carries compare values and match results between top and matcher
// Assumes: one clock domain
// Notes: plain wires
`timescale 1ns/1ps
interface cmp_bus_if;
  logic [7:0] a_low;
  logic [7:0] b_high;
  logic [7:0] b_low;
  logic [7:0] c_high;
  logic [7:0] c_low;
  logic full_mode;
  logic a_hit;
  logic b_hit;
  logic c_hit;
  modport regs (output a_low, b_high, b_low, c_high, c_low, full_mode, input a_hit, b_hit, c_hit);
  modport match (input a_low, b_high, b_low, c_high, c_low, full_mode, output a_hit, b_hit, c_hit);
endinterface : cmp_bus_if

// *** logic/cmp_matcher.sv ***
// Purpose: bitwise comparison of programmed values against cpu buses
// Assumes: cpu buses are on clk_sys
// Notes: hits are registered
`timescale 1ns/1ps
module cmp_matcher (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, active high
  input wire logic [15:0] cpu_addr, // cpu address bus
  input wire logic [7:0] cpu_data, // cpu data bus
  input wire logic [7:0] a_high, // comparator a high byte, held outside
  cmp_bus_if.match cb // compare values and hits
);
  typedef struct packed {
    logic a_hit;
    logic b_hit;
    logic c_hit;
  } match_st_t;
  match_st_t st_r;
  match_st_t st_nxt;
  logic [7:0] b_low_src;

  always_comb begin
    st_nxt = st_r;
    // stored bit must equal bus bit, 0 wants low and 1 wants high
    b_low_src = cb.full_mode ? cpu_data : cpu_addr[7:0];
    st_nxt.a_hit = ({a_high, cb.a_low} == cpu_addr);
    // full mode drops the b high byte from the decision
    st_nxt.b_hit = (cb.b_low == b_low_src)
      && (cb.full_mode || (cb.b_high == cpu_addr[15:8]));
    st_nxt.c_hit = (cb.c_high == cpu_addr[15:8]) && (cb.c_low == cpu_addr[7:0]);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cb.a_hit = st_r.a_hit;
  assign cb.b_hit = st_r.b_hit;
  assign cb.c_hit = st_r.c_hit;
endmodule : cmp_matcher

// *** logic/trace_store.sv ***
// Purpose: trace word storage with a read pointer that pops on demand
// Assumes: writer never pushes into a full store
// Notes: depth fixed
`timescale 1ns/1ps
`include "dbg_cmp_params.svh"
module trace_store (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, active high
  input wire logic clr, // synchronous clear
  input wire logic push, // store one word
  input wire logic [15:0] push_word, // word to store
  input wire logic pop, // advance read pointer
  output logic [15:0] head_word, // word at read location
  output logic head_valid, // a word is present
  output logic [`FIFO_PTR_W:0] count // words held
);
  typedef struct packed {
    logic [`FIFO_PTR_W-1:0] wp;
    logic [`FIFO_PTR_W-1:0] rp;
    logic [`FIFO_PTR_W:0] cnt;
  } ptr_st_t;
  ptr_st_t st_r;
  ptr_st_t st_nxt;
  logic [15:0] mem [`FIFO_DEPTH];
  logic do_push;
  logic do_pop;

  always_comb begin
    st_nxt = st_r;
    do_push = push && (st_r.cnt != `FIFO_PTR_W'(0) + (`FIFO_PTR_W+1)'(`FIFO_DEPTH));
    do_pop = pop && (st_r.cnt != '0);
    if (do_push) begin
      st_nxt.wp = st_r.wp + `FIFO_PTR_W'(1);
    end
    if (do_pop) begin
      st_nxt.rp = st_r.rp + `FIFO_PTR_W'(1);
    end
    st_nxt.cnt = st_r.cnt + (`FIFO_PTR_W+1)'(do_push) - (`FIFO_PTR_W+1)'(do_pop);
    if (clr) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // storage has no reset; only the pointers matter
  always_ff @(posedge clk_sys) begin
    if (do_push && !clr) begin
      mem[st_r.wp] <= push_word;
    end
  end

  assign head_word = mem[st_r.rp];
  assign head_valid = (st_r.cnt != '0);
  assign count = st_r.cnt;
endmodule : trace_store

// *** logic/debug_compare_trace_regs.sv ***
// Purpose: comparator low/high bytes and trace readout registers on APB
// Assumes: cpu buses and trace pushes are synchronous to clk_sys
// Notes: zero-wait APB slave; end-trace reset keeps comparator values
//
// Function
// - comparator a low byte matches address 7:0
// - comparator b high matches address 15:8
// - full mode ignores comparator b high
// - b low matches data in full mode
// - comparator c high matches address 15:8
// - comparator c low matches address 7:0
// - stored 0 wants low, 1 wants high
// - end-trace reset keeps comparator values
// - other resets clear b high, c low
// - trace high returns word bits 15:8
// - event-only modes read high as zero
// - trace low returns word low byte
// - reading trace low advances pointer
// - full: a address, b data
// - trace registers read-only, writes ignored
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "dbg_cmp_params.svh"
module debug_compare_trace_regs (
  input wire logic clk_sys, // system clock 125 MHz
  input wire logic rst, // async power-on reset, active high
  input wire logic sys_reset, // synchronous mcu reset request, active high
  input wire logic [7:0] cmp_a_high, // comparator a high byte from its own register
  input wire logic [15:0] cpu_addr, // cpu address bus
  input wire logic [7:0] cpu_data, // cpu data bus
  input wire logic trace_push, // store a trace word
  input wire logic [15:0] trace_data, // trace word to store
  input wire logic [31:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error for unmapped address
  output logic match_a, // comparator a hit
  output logic match_b, // comparator b hit
  output logic match_c // comparator c hit
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    dbg_cmp_pkg::byte_t a_low;
    dbg_cmp_pkg::byte_t b_high;
    dbg_cmp_pkg::byte_t b_low;
    dbg_cmp_pkg::byte_t c_high;
    dbg_cmp_pkg::byte_t c_low;
    dbg_cmp_pkg::byte_t ctrl;
    logic [31:0] rdata;
    logic slverr;
  } regs_st_t;
  regs_st_t st_r;
  regs_st_t st_nxt;

  cmp_bus_if cb ();
  logic acc;
  logic wr;
  logic rd;
  logic [3:0] idx;
  logic mapped;
  logic end_trace;
  logic pop;
  logic [15:0] head_word;
  logic head_valid;
  logic [`FIFO_PTR_W:0] fifo_count;
  logic event_only;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign idx = paddr[`IDX_MSB:`IDX_LSB];
  assign mapped = (paddr[31:`IDX_MSB+1] == '0) && (paddr[1:0] == 2'h0)
    && (idx >= `IDX_CMP_A_ADDR_LOW) && (idx <= `IDX_STATUS);
  assign event_only = st_r.ctrl[`CTRL_EVONLY_BIT];
  // end-trace reset: enable set and begin-trace select clear
  assign end_trace = st_r.ctrl[`CTRL_ENABLE_BIT] && !st_r.ctrl[`CTRL_BEGIN_BIT];
  assign pop = rd && mapped && (idx == `IDX_TRACE_WORD_LOW);

  // ****************************************************************
  // register update
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    if (wr && mapped && pstrb[0]) begin
      case (idx)
        `IDX_CMP_A_ADDR_LOW: st_nxt.a_low = pwdata[7:0];
        `IDX_CMP_B_ADDR_HIGH: st_nxt.b_high = pwdata[7:0];
        `IDX_CMP_B_ADDR_DATA_LOW: st_nxt.b_low = pwdata[7:0];
        `IDX_CMP_C_ADDR_HIGH: st_nxt.c_high = pwdata[7:0];
        `IDX_CMP_C_ADDR_LOW: st_nxt.c_low = pwdata[7:0];
        `IDX_CTRL: st_nxt.ctrl = pwdata[7:0];
        default: st_nxt.ctrl = st_r.ctrl;
      endcase
    end
    st_nxt.rdata = '0;
    if (rd && mapped) begin
      case (idx)
        `IDX_CMP_A_ADDR_LOW: st_nxt.rdata[7:0] = st_r.a_low;
        `IDX_CMP_B_ADDR_HIGH: st_nxt.rdata[7:0] = st_r.b_high;
        `IDX_CMP_B_ADDR_DATA_LOW: st_nxt.rdata[7:0] = st_r.b_low;
        `IDX_CMP_C_ADDR_HIGH: st_nxt.rdata[7:0] = st_r.c_high;
        `IDX_CMP_C_ADDR_LOW: st_nxt.rdata[7:0] = st_r.c_low;
        `IDX_TRACE_WORD_HIGH: begin
          // event-only words carry no high byte
          st_nxt.rdata[7:0] = event_only ? `BYTE_ZERO : head_word[15:8];
        end
        `IDX_TRACE_WORD_LOW: st_nxt.rdata[7:0] = head_word[7:0];
        `IDX_CTRL: st_nxt.rdata[7:0] = st_r.ctrl;
        `IDX_STATUS: st_nxt.rdata[15:0] = {head_valid, 11'h000, fifo_count};
        default: st_nxt.rdata = '0;
      endcase
    end
    st_nxt.slverr = acc && !mapped;
    // mcu reset: comparators survive only an end-trace reset
    if (sys_reset && !end_trace) begin
      st_nxt.a_low = `RST_CMP_A_ADDR_LOW;
      st_nxt.b_high = `RST_CMP_B_ADDR_HIGH;
      st_nxt.b_low = `RST_CMP_B_ADDR_DATA_LOW;
      st_nxt.c_high = `RST_CMP_C_ADDR_HIGH;
      st_nxt.c_low = `RST_CMP_C_ADDR_LOW;
      st_nxt.ctrl = '0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // comparators and trace store
  // ****************************************************************
  assign cb.a_low = st_r.a_low;
  assign cb.b_high = st_r.b_high;
  assign cb.b_low = st_r.b_low;
  assign cb.c_high = st_r.c_high;
  assign cb.c_low = st_r.c_low;
  assign cb.full_mode = st_r.ctrl[`CTRL_FULL_BIT];

  cmp_matcher u_match (
    .clk_sys(clk_sys),
    .rst(rst),
    .cpu_addr(cpu_addr),
    .cpu_data(cpu_data),
    .a_high(cmp_a_high),
    .cb(cb)
  );

  trace_store u_store (
    .clk_sys(clk_sys),
    .rst(rst),
    .clr(sys_reset && !end_trace),
    .push(trace_push),
    .push_word(trace_data),
    .pop(pop),
    .head_word(head_word),
    .head_valid(head_valid),
    .count(fifo_count)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  // zero wait states; data registered one cycle behind would break apb, so read live
  assign pready = 1'b1;
  assign prdata = st_nxt.rdata;
  assign pslverr = acc && !mapped;
  assign match_a = cb.a_hit;
  assign match_b = cb.b_hit;
  assign match_c = cb.c_hit;
endmodule : debug_compare_trace_regs

// *** verification/dbg_cmp_asserts.sv ***
// Purpose: port checks of the compare/trace block
// Assumes: zero-wait apb slave
// Notes: bound after endmodule
`timescale 1ns/1ps
module dbg_cmp_asserts (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic sys_reset, // mcu reset
  input wire logic trace_push, // push
  input wire logic [31:0] paddr, // addr
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // dir
  input wire logic [31:0] pwdata, // wdata
  input wire logic [3:0] pstrb, // strobes
  input wire logic [31:0] prdata, // rdata
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic match_a, // hit a
  input wire logic match_b // hit b
);
  // ****
  // properties
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic acc;
  logic rd_fh;
  assign acc = psel && penable;
  assign rd_fh = acc && !pwrite && paddr == 32'h18 && !trace_push;
  ready_always_a: assert property (acc |-> pready)
    else $error("pready low in access");
  err_phase_a: assert property (pslverr |-> acc)
    else $error("pslverr outside access");
  unmapped_a: assert property (acc && paddr > 32'h24 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access answered");
  mapped_a: assert property (acc && paddr inside {[32'h4:32'h24]} |-> !pslverr)
    else $error("mapped access refused");
  byte_wide_a: assert property (
    acc && !pwrite && paddr inside {32'h18, 32'h1c} |-> prdata[31:8] == 24'h0)
    else $error("trace read above byte");
  cmp_readback_a: assert property (
    acc && pwrite && pstrb[0] && !sys_reset && paddr inside {[32'h4:32'h14]}
    ##1 (!acc && !sys_reset)[*2] ##1 acc && !pwrite && paddr == $past(paddr, 3)
    |-> prdata[7:0] == $past(pwdata[7:0], 3))
    else $error("compare byte lost");
  fh_hold_a: assert property (
    rd_fh ##1 (!acc && !trace_push && !sys_reset)[*2] ##1 rd_fh
    |-> prdata == $past(prdata, 3))
    else $error("high read moved pointer");
  // a control write could switch to event-only, so it is excluded
  fh_wr_ignored_a: assert property (
    rd_fh ##1 (!(acc && (!pwrite || paddr == 32'h20)) && !trace_push && !sys_reset)[*5]
    ##1 rd_fh |-> prdata == $past(prdata, 6))
    else $error("trace write took effect");
  cover property (match_a);
  cover property (match_a && match_b);
  cover property (rd_fh);
endmodule : dbg_cmp_asserts
bind debug_compare_trace_regs dbg_cmp_asserts u_dbg_cmp_asserts (.clk_sys(clk_sys),
  .rst(rst), .sys_reset(sys_reset), .trace_push(trace_push), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .match_a(match_a), .match_b(match_b));

// *** verification/cpu_side_model.sv ***
// Purpose: cpu buses and trace source
// Assumes: called right after a rising edge
// Notes: trace data inverted once released
`timescale 1ns/1ps
module cpu_side_model (
  input wire logic clk_sys, // clock
  output logic [15:0] cpu_addr, // address bus
  output logic [7:0] cpu_data, // data bus
  output logic trace_push, // push strobe
  output logic [15:0] trace_data // trace word
);
  // ****
  // drivers
  // ****
  initial begin
    cpu_addr = 16'h0;
    cpu_data = 8'h0;
    trace_push = 1'b0;
    trace_data = 16'h0;
  end
  task put(input logic [15:0] a, input logic [7:0] d);
    cpu_addr <= a;
    cpu_data <= d;
  endtask : put
  task push(input logic [15:0] w);
    trace_push <= 1'b1;
    trace_data <= w;
    @(posedge clk_sys);
    trace_push <= 1'b0;
    // stale data must not pass for a held word
    trace_data <= ~w;
    @(posedge clk_sys);
  endtask : push
endmodule : cpu_side_model

// *** verification/testbench.sv ***
// Purpose: directed checks of the compare/trace block
// Assumes: zero-wait apb, store depth 8
// Notes: one task per scenario
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic sys_reset = 1'b0;
  logic [7:0] cmp_a_high = 8'h12;
  logic [31:0] paddr = 32'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic match_a;
  logic match_b;
  logic match_c;
  logic [15:0] cpu_addr;
  logic [7:0] cpu_data;
  logic trace_push;
  logic [15:0] trace_data;
  logic [31:0] q;
  logic err;
  int err_total = 0;
  int n_checks = 0;
  always #4 clk_sys = ~clk_sys;
  debug_compare_trace_regs u_debug_compare_trace_regs (.clk_sys(clk_sys), .rst(rst),
    .sys_reset(sys_reset), .cmp_a_high(cmp_a_high), .cpu_addr(cpu_addr),
    .cpu_data(cpu_data), .trace_push(trace_push), .trace_data(trace_data), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .match_a(match_a),
    .match_b(match_b), .match_c(match_c));
  cpu_side_model u_cpu_side_model (.clk_sys(clk_sys), .cpu_addr(cpu_addr),
    .cpu_data(cpu_data), .trace_push(trace_push), .trace_data(trace_data));
  // ****
  // helpers
  // ****
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a stuck access
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle keeps every drive to one per time step
    @(posedge clk_sys);
  endtask : apb
  task rd(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task hit(input logic [15:0] a, input logic [7:0] d, input logic [2:0] e);
    u_cpu_side_model.put(a, d);
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({29'h0, match_a, match_b, match_c}, {29'h0, e});
    @(posedge clk_sys);
  endtask : hit
  task pulse;
    sys_reset <= 1'b1;
    @(posedge clk_sys);
    sys_reset <= 1'b0;
    @(posedge clk_sys);
  endtask : pulse
  // ****
  // scenarios
  // ****
  task t_match;
    for (int i = 1; i < 6; i++) begin
      rd(32'(i * 4), 32'h0);
    end
    apb(1'b1, 32'h04, 32'h34);
    apb(1'b1, 32'h08, 32'h56);
    apb(1'b1, 32'h0c, 32'h78);
    apb(1'b1, 32'h10, 32'h9a);
    apb(1'b1, 32'h14, 32'hbc);
    apb(1'b1, 32'h20, 32'h00);
    hit(16'h1234, 8'h00, 3'b100);
    hit(16'h1235, 8'h00, 3'b000);
    hit(16'h5678, 8'h00, 3'b010);
    hit(16'h9abc, 8'h00, 3'b001);
    hit(16'h9bbc, 8'h00, 3'b000);
    apb(1'b1, 32'h20, 32'h01);
    hit(16'h1234, 8'h78, 3'b110);
    hit(16'h5678, 8'h00, 3'b000);
    $display("test match done");
  endtask : t_match
  task t_trace;
    apb(1'b1, 32'h20, 32'h00);
    u_cpu_side_model.push(16'h1234);
    u_cpu_side_model.push(16'h5678);
    u_cpu_side_model.push(16'h9abc);
    rd(32'h24, 32'h00008003);
    rd(32'h18, 32'h12);
    rd(32'h18, 32'h12);
    apb(1'b1, 32'h1c, 32'hff);
    rd(32'h18, 32'h12);
    rd(32'h1c, 32'h34);
    apb(1'b1, 32'h18, 32'hff);
    rd(32'h18, 32'h56);
    apb(1'b1, 32'h20, 32'h02);
    rd(32'h18, 32'h00);
    rd(32'h1c, 32'h78);
    rd(32'h1c, 32'hbc);
    apb(1'b1, 32'h40, 32'h77);
    rd(32'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    rd(32'h04, 32'h34);
    $display("test trace done");
  endtask : t_trace
  task t_rst;
    apb(1'b1, 32'h14, 32'ha5);
    rd(32'h14, 32'ha5);
    apb(1'b1, 32'h20, 32'h80);
    u_cpu_side_model.push(16'h4321);
    pulse();
    rd(32'h08, 32'h56);
    rd(32'h14, 32'ha5);
    rd(32'h24, 32'h00008001);
    apb(1'b1, 32'h20, 32'h00);
    pulse();
    rd(32'h08, 32'h00);
    rd(32'h14, 32'h00);
    rd(32'h24, 32'h00000000);
    $display("test reset done");
  endtask : t_rst
  task close_out;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_match();
    t_trace();
    t_rst();
    close_out();
  end
  initial begin
    #100000;
    err_total++;
    close_out();
  end
endmodule : testbench
